//--- core/prdc_pkg.sv
// Constants, offsets and reset values for the PLL ratio and divider control
package prdc_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int FRAC_W = 22;
  localparam int INT_W  = 4;
  localparam int MULT_W = INT_W + FRAC_W;

  localparam logic [ADDR_W-1:0] OFS_FRAC_LOW  = 7'h03;
  localparam logic [ADDR_W-1:0] OFS_FRAC_MID  = 7'h04;
  localparam logic [ADDR_W-1:0] OFS_FRAC_HIGH = 7'h05;
  localparam logic [ADDR_W-1:0] OFS_INT_PRE   = 7'h06;
  localparam logic [ADDR_W-1:0] OFS_OUT_DIV   = 7'h07;

  localparam logic [DATA_W-1:0] RST_FRAC_LOW  = 8'h21;
  localparam logic [DATA_W-1:0] RST_FRAC_MID  = 8'hfd;
  localparam logic [DATA_W-1:0] RST_FRAC_HIGH = 8'h36;
  localparam logic [DATA_W-1:0] RST_INT_PRE   = 8'h07;
  localparam logic [DATA_W-1:0] RST_OUT_DIV   = 8'h06;

  localparam int POS_INT_LSB   = 0;
  localparam int POS_HALVER    = 4;
  localparam int POS_POST_LSB  = 0;
  localparam int FRAC_HIGH_W   = 6;
  localparam int POST_W        = 2;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  typedef enum logic {PRDC_USER, PRDC_AUTO} prdc_mode_t;
endpackage

//--- core/prdc_ctrl.sv
// PLL ratio and divider register file with user/automatic mode selection
`timescale 1ns/1ps
module prdc_ctrl
  import prdc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              rx_enable,
  input  wire logic [INT_W-1:0]  auto_integer,
  input  wire logic [FRAC_W-1:0] auto_fraction,
  input  wire logic [POST_W-1:0] auto_post_divider,
  output logic                   pll_auto_mode,
  output logic [INT_W-1:0]       pll_integer,
  output logic [FRAC_W-1:0]      pll_fraction,
  output logic [MULT_W-1:0]      pll_multiplier,
  output logic                   pll_input_halver,
  output logic [POST_W-1:0]      post_divider_select
);

  logic [DATA_W-1:0] frac_low_r,  frac_low_nxt;
  logic [DATA_W-1:0] frac_mid_r,  frac_mid_nxt;
  logic [DATA_W-1:0] frac_high_r, frac_high_nxt;
  logic [DATA_W-1:0] int_pre_r,   int_pre_nxt;
  logic [DATA_W-1:0] out_div_r,   out_div_nxt;
  logic [DATA_W-1:0] rdata_r,     rdata_nxt;

  prdc_mode_t        mode_r,      mode_nxt;
  logic [INT_W-1:0]  int_r,       int_nxt;
  logic [FRAC_W-1:0] frac_r,      frac_nxt;
  logic [MULT_W-1:0] mult_r,      mult_nxt;
  logic              halver_r,    halver_nxt;
  logic [POST_W-1:0] post_r,      post_nxt;

  logic [FRAC_W-1:0] user_frac;
  logic [INT_W-1:0]  user_int;

  function automatic logic [MULT_W-1:0] ratio_word(input logic [INT_W-1:0]  n,
                                                   input logic [FRAC_W-1:0] k);
    ratio_word = {n, k}; // Fixed point: n + k / 2^22
  endfunction

  // Register file
  // Spare bits are stored too, so software reads back what it wrote, except the OFS_OUT_DIV divider bits, which show the receiver value in auto mode
  always_comb begin
    frac_low_nxt  = frac_low_r;
    frac_mid_nxt  = frac_mid_r;
    frac_high_nxt = frac_high_r;
    int_pre_nxt   = int_pre_r;
    out_div_nxt   = out_div_r;
    rdata_nxt     = rdata_r;
    if (reg_write) begin
      unique case (reg_addr)
        OFS_FRAC_LOW:  frac_low_nxt  = reg_wdata;
        OFS_FRAC_MID:  frac_mid_nxt  = reg_wdata;
        OFS_FRAC_HIGH: frac_high_nxt = reg_wdata;
        OFS_INT_PRE:   int_pre_nxt   = reg_wdata;
        OFS_OUT_DIV:   out_div_nxt   = reg_wdata; // Software value kept even in auto
        default:       ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        OFS_FRAC_LOW:  rdata_nxt = frac_low_r;
        OFS_FRAC_MID:  rdata_nxt = frac_mid_r;
        OFS_FRAC_HIGH: rdata_nxt = frac_high_r;
        OFS_INT_PRE:   rdata_nxt = int_pre_r;
        // Reads show the divider in use, so receiver overrides are visible
        OFS_OUT_DIV:   rdata_nxt = {out_div_r[DATA_W-1:POST_W], post_r};
        default:       rdata_nxt = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frac_low_r  <= RST_FRAC_LOW;
      frac_mid_r  <= RST_FRAC_MID;
      frac_high_r <= RST_FRAC_HIGH;
      int_pre_r   <= RST_INT_PRE;
      out_div_r   <= RST_OUT_DIV;
      rdata_r     <= READ_UNMAPPED;
    end else begin
      frac_low_r  <= frac_low_nxt;
      frac_mid_r  <= frac_mid_nxt;
      frac_high_r <= frac_high_nxt;
      int_pre_r   <= int_pre_nxt;
      out_div_r   <= out_div_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // PLL control selection
  // Every control output is registered so the synthesiser never sees decode glitches
  assign user_frac = {frac_high_r[FRAC_HIGH_W-1:0], frac_mid_r, frac_low_r};
  assign user_int  = int_pre_r[POS_INT_LSB +: INT_W];

  always_comb begin
    mode_nxt   = rx_enable ? PRDC_AUTO : PRDC_USER;
    // Halver stays with software in both modes; the receiver never drives it
    halver_nxt = int_pre_r[POS_HALVER];
    if (rx_enable) begin
      int_nxt  = auto_integer;
      frac_nxt = auto_fraction;
      post_nxt = auto_post_divider;
    end else begin
      int_nxt  = user_int;
      frac_nxt = user_frac;
      post_nxt = out_div_r[POS_POST_LSB +: POST_W];
    end
    mult_nxt = ratio_word(int_nxt, frac_nxt);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_r   <= PRDC_USER;
      int_r    <= RST_INT_PRE[POS_INT_LSB +: INT_W];
      frac_r   <= {RST_FRAC_HIGH[FRAC_HIGH_W-1:0], RST_FRAC_MID, RST_FRAC_LOW};
      mult_r   <= {RST_INT_PRE[POS_INT_LSB +: INT_W], RST_FRAC_HIGH[FRAC_HIGH_W-1:0],
                   RST_FRAC_MID, RST_FRAC_LOW};
      halver_r <= RST_INT_PRE[POS_HALVER];
      post_r   <= RST_OUT_DIV[POS_POST_LSB +: POST_W];
    end else begin
      mode_r   <= mode_nxt;
      int_r    <= int_nxt;
      frac_r   <= frac_nxt;
      mult_r   <= mult_nxt;
      halver_r <= halver_nxt;
      post_r   <= post_nxt;
    end
  end

  assign reg_rdata           = rdata_r;
  assign pll_auto_mode       = (mode_r == PRDC_AUTO);
  assign pll_integer         = int_r;
  assign pll_fraction        = frac_r;
  assign pll_multiplier      = mult_r;
  assign pll_input_halver    = halver_r;
  assign post_divider_select = post_r;

  // Checks on mode, ratio, halver and post divider selection
  chk_user_mode_sel: assert property (@(posedge clock) disable iff (!nrst)
    !rx_enable |=> !pll_auto_mode) else $error("user mode not taken");
  chk_auto_mode_sel: assert property (@(posedge clock) disable iff (!nrst)
    rx_enable |=> pll_auto_mode && pll_integer == $past(auto_integer)
                  && pll_fraction == $past(auto_fraction))
    else $error("auto mode values not followed");
  chk_user_values: assert property (@(posedge clock) disable iff (!nrst)
    !rx_enable ##1 !rx_enable && !$past(reg_write) |->
      pll_integer == int_pre_r[3:0]
      && pll_fraction == {frac_high_r[5:0], frac_mid_r, frac_low_r})
    else $error("user ratio mismatch");
  chk_frac_low: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h03 && !rx_enable ##1 !rx_enable |=>
      pll_fraction[7:0] == $past(reg_wdata, 2))
    else $error("fraction low byte not placed");
  chk_frac_mid: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h04 && !rx_enable ##1 !rx_enable |=>
      pll_fraction[15:8] == $past(reg_wdata, 2))
    else $error("fraction middle byte not placed");
  chk_frac_write: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h05 && !rx_enable ##1 !rx_enable |=>
      pll_fraction[21:16] == $past(reg_wdata[5:0], 2))
    else $error("fraction high byte not placed");
  chk_int_write: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h06 && !rx_enable ##1 !rx_enable |=>
      pll_integer == $past(reg_wdata[3:0], 2) && pll_input_halver == $past(reg_wdata[4], 2))
    else $error("integer or halver not applied");
  chk_halver_auto: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h06 && rx_enable ##1 rx_enable |=>
      pll_input_halver == $past(reg_wdata[4], 2))
    else $error("halver not applied in auto mode");
  chk_ratio_sum: assert property (@(posedge clock) disable iff (!nrst)
    pll_multiplier == (26'(pll_integer) << 22) + 26'(pll_fraction))
    else $error("multiplier not integer plus fraction");
  chk_post_user: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h07 && !rx_enable ##1 !rx_enable |=>
      post_divider_select == $past(reg_wdata[1:0], 2))
    else $error("post divider write not applied");
  chk_post_auto: assert property (@(posedge clock) disable iff (!nrst)
    rx_enable |=> post_divider_select == $past(auto_post_divider))
    else $error("receiver post divider not forced");
  chk_post_ignored: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h07 && rx_enable ##1 rx_enable |=>
      post_divider_select == $past(auto_post_divider))
    else $error("software post divider used in auto mode");
  chk_reset_vals: assert property (@(posedge clock)
    $rose(nrst) |-> pll_fraction == 22'h36fd21 && pll_integer == 4'h7
                    && post_divider_select == 2'h2 && !pll_auto_mode
                    && !pll_input_halver && pll_multiplier == {4'h7, 22'h36fd21})
    else $error("reset values wrong");

  // Checks on the register side
  chk_post_stored: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h07 |=> out_div_r == $past(reg_wdata))
    else $error("divider byte not stored");
  chk_post_read: assert property (@(posedge clock) disable iff (!nrst)
    reg_read && reg_addr == 7'h07 |=> reg_rdata[1:0] == $past(post_divider_select))
    else $error("divider read does not show value in use");
  chk_unmapped_read: assert property (@(posedge clock) disable iff (!nrst)
    reg_read && reg_addr > 7'h07 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_unmapped_write: assert property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr > 7'h07 |=> $stable(frac_low_r) && $stable(frac_mid_r)
      && $stable(frac_high_r) && $stable(int_pre_r) && $stable(out_div_r))
    else $error("unmapped write changed a register");
  chk_read_hold: assert property (@(posedge clock) disable iff (!nrst)
    !reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  cov_auto_entry: cover property (@(posedge clock) disable iff (!nrst) $rose(pll_auto_mode));
  cov_auto_exit:  cover property (@(posedge clock) disable iff (!nrst) $fell(pll_auto_mode));
  cov_int_write:  cover property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h06 && !rx_enable);
  cov_read_back:  cover property (@(posedge clock) disable iff (!nrst)
    reg_read && reg_addr == 7'h03);
  cov_auto_post_write: cover property (@(posedge clock) disable iff (!nrst)
    reg_write && reg_addr == 7'h07 && rx_enable);

endmodule

//--- bench/prdc_ctrl_tb_top.sv
// Self-checking bench for the PLL ratio and divider control registers
`timescale 1ns/1ps
module prdc_ctrl_tb_top;
  import prdc_pkg::*;
  logic              clock = 1'b0;
  logic              nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              rx_enable = 1'b0;
  logic [INT_W-1:0]  auto_integer = 4'h9;
  logic [FRAC_W-1:0] auto_fraction = 22'h2c2b24;
  logic [POST_W-1:0] auto_post_divider = 2'h1;
  logic              pll_auto_mode;
  logic [INT_W-1:0]  pll_integer;
  logic [FRAC_W-1:0] pll_fraction;
  logic [MULT_W-1:0] pll_multiplier;
  logic              pll_input_halver;
  logic [POST_W-1:0] post_divider_select;
  int                error_cnt = 0;
  int                tests_run = 0;

  always #50 clock = ~clock;

  prdc_ctrl i_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_enable(rx_enable), .auto_integer(auto_integer), .auto_fraction(auto_fraction),
    .auto_post_divider(auto_post_divider), .pll_auto_mode(pll_auto_mode),
    .pll_integer(pll_integer), .pll_fraction(pll_fraction),
    .pll_multiplier(pll_multiplier), .pll_input_halver(pll_input_halver),
    .post_divider_select(post_divider_select));

  task automatic chk(input string what, input logic [MULT_W-1:0] exp,
                     input logic [MULT_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    chk("reg_rdata", MULT_W'(exp), MULT_W'(reg_rdata));
  endtask

  // Two edges cover the register write plus the output stage
  task automatic outs(input logic m, input logic [INT_W-1:0] i, input logic [FRAC_W-1:0] f,
                      input logic h, input logic [POST_W-1:0] p);
    repeat (2) @(negedge clock);
    chk("pll_auto_mode", MULT_W'(m), MULT_W'(pll_auto_mode));
    chk("pll_integer", MULT_W'(i), MULT_W'(pll_integer));
    chk("pll_fraction", MULT_W'(f), MULT_W'(pll_fraction));
    chk("pll_multiplier", {i, f}, pll_multiplier);
    chk("pll_input_halver", MULT_W'(h), MULT_W'(pll_input_halver));
    chk("post_divider_select", MULT_W'(p), MULT_W'(post_divider_select));
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Sequence needs under 10 us; the limit leaves a tenfold margin
  initial begin
    #100us;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    outs(1'b0, 4'h7, 22'h36fd21, 1'b0, 2'h2);
    rd(OFS_FRAC_LOW, RST_FRAC_LOW);
    rd(OFS_FRAC_MID, RST_FRAC_MID);
    rd(OFS_FRAC_HIGH, RST_FRAC_HIGH);
    rd(OFS_INT_PRE, RST_INT_PRE);
    rd(OFS_OUT_DIV, RST_OUT_DIV);
    wr(OFS_FRAC_LOW, 8'hba);
    wr(OFS_FRAC_MID, 8'h49);
    wr(OFS_FRAC_HIGH, 8'hcc);
    wr(OFS_INT_PRE, 8'h18);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_OUT_DIV, 8'h04 | 8'(p));
      outs(1'b0, 4'h8, 22'h0c49ba, 1'b1, 2'(p));
      rd(OFS_OUT_DIV, 8'h04 | 8'(p));
    end
    rd(OFS_FRAC_HIGH, 8'hcc);
    // Unmapped space must neither store nor echo
    wr(7'h08, 8'h5a);
    rd(7'h08, READ_UNMAPPED);
    rd(OFS_INT_PRE, 8'h18);
    wr(OFS_INT_PRE, 8'h05);
    outs(1'b0, 4'h5, 22'h0c49ba, 1'b0, 2'h3);
    rx_enable = 1'b1;
    outs(1'b1, 4'h9, 22'h2c2b24, 1'b0, 2'h1);
    rd(OFS_OUT_DIV, 8'h05);
    rd(OFS_INT_PRE, 8'h05);
    auto_integer = 4'hd;
    auto_fraction = 22'h21b089;
    auto_post_divider = 2'h2;
    outs(1'b1, 4'hd, 22'h21b089, 1'b0, 2'h2);
    // Software writes while the receiver owns the PLL
    wr(OFS_OUT_DIV, 8'h04);
    wr(OFS_INT_PRE, 8'h18);
    outs(1'b1, 4'hd, 22'h21b089, 1'b1, 2'h2);
    rd(OFS_OUT_DIV, 8'h06);
    rx_enable = 1'b0;
    outs(1'b0, 4'h8, 22'h0c49ba, 1'b1, 2'h0);
    rd(OFS_OUT_DIV, 8'h04);
    // Mid-run reset must restore every register
    nrst = 1'b0;
    @(negedge clock);
    nrst = 1'b1;
    outs(1'b0, 4'h7, 22'h36fd21, 1'b0, 2'h2);
    rd(OFS_INT_PRE, RST_INT_PRE);
    end_of_test();
  end
endmodule
